// ### logic/bpc_pkg.sv
// Purpose: constants and types for the brushless pre-driver control block
// Assumes: 20 MHz aclk, AXI4-Lite register access, 32-bit data
// Notes: timing counts are derived from the nominal durations
//
// Behaviour
// [R1] sense trip clears the source enable
// [R2] source held off for 25 us
// [R3] enable low drives selected sink-source pair
// [R4] enable high chops sources, slow decay
// [R5] enable high over 3 ms disables gates
// [R6] blank sense 1.5 us after off-time
// [R7] direction change or enable-on restarts blanking
// [R8] synchronous rectification during decay when enabled and no overvoltage
// [R9] brake low turns on all sinks
// [R10] brake beats enable and lock timer
// [R11] standby after 3 ms enable high, hall supply off
// [R12] controller keeps brake high to reach standby
// [R13] temperature or undervoltage faults disable outputs
// [R14] undervoltage lockout holds drivers off at power-up
// [R15] overvoltage suppresses synchronous rectification
// [R16] thermal shutdown disables outputs until hysteresis clears
// [R17] all-sensor speed toggles on any hall edge
// [R18] phase-a speed toggles on hall a edge
// [R19] lock when hall stops or sequence breaks
// [R20] lock must persist 127 triangle cycles
// [R21] lock timeout disables outputs and latches fault
// [R22] lock clears on dir edge, uvlo, enable-high
// [R23] six-state commutation table, invalid halls off
// [R24] timers are counters on the internal clock
package bpc_pkg;
  // =====================================================
  // timing
  localparam int CLK_HZ = 20000000;
  localparam int CLK_PERIOD_NS = 1000000000 / CLK_HZ;
  localparam int OFF_TIME_NS = 25000;
  localparam int OFF_CYCLES = OFF_TIME_NS / CLK_PERIOD_NS;
  localparam int BLANK_TIME_NS = 1500;
  localparam int BLANK_CYCLES = (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EN_HIGH_TIME_MS = 3;
  localparam int EN_HIGH_CYCLES = EN_HIGH_TIME_MS * (CLK_HZ / 1000);
  localparam int LOCK_TRI_CYCLES = 127;
  localparam int LOCK_HALF_CYCLES = LOCK_TRI_CYCLES / 2 + 1;
  // =====================================================
  // registers
  localparam logic [31:0] CTRL_ADDR = 32'h0000_0000;
  localparam logic [31:0] STATUS_ADDR = 32'h0000_0004;
  localparam int CTRL_SR_EN_BIT = 0;
  localparam int CTRL_LOCK_EN_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [1:0] {SEL_CTRL, SEL_STATUS, SEL_NONE} bpc_sel_t;
  typedef enum logic [1:0] {CH_BLANK, CH_DRIVE, CH_OFF} bpc_chop_t;
endpackage

// ### logic/bpc_top.sv
// Purpose: control logic of a three-phase brushless motor pre-driver
// Assumes: all pins synchronous to aclk; lock_timer_capacitor is the triangle oscillator as a square wave
// Notes: gate outputs are registered, two aclk after a sense trip or lock timeout, one aclk after any other cause
`timescale 1ns/1ps
`default_nettype none
module bpc_top
  import bpc_pkg::*;
#(
  parameter int EN_HIGH_LIMIT = EN_HIGH_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic drive_enable_n,
  input wire logic direction,
  input wire logic brake_request_n,
  input wire logic hall_sensor_a,
  input wire logic hall_sensor_b,
  input wire logic hall_sensor_c,
  input wire logic sense_trip,
  input wire logic overtemp,
  input wire logic pump_undervoltage,
  input wire logic supply_undervoltage,
  input wire logic supply_overvoltage,
  input wire logic lock_timer_capacitor,
  output logic [2:0] gate_high,
  output logic [2:0] gate_low,
  output logic hall_supply_output,
  output logic speed_pulse_all_sensors,
  output logic speed_pulse_phase_a
);

  // =====================================================
  // helpers
  function automatic bpc_sel_t reg_sel(input logic [31:0] addr);
    if (addr == CTRL_ADDR) begin
      return SEL_CTRL;
    end else if (addr == STATUS_ADDR) begin
      return SEL_STATUS;
    end
    return SEL_NONE;
  endfunction

  // returns {high[2:0], low[2:0]}, bit 0 is phase a
  function automatic logic [5:0] commutate(input logic [2:0] h, input logic fwd);
    logic [5:0] g;
    g = 6'h00;
    case (h)
      3'b101: g = fwd ? 6'b001_010 : 6'b010_001;
      3'b001: g = fwd ? 6'b001_100 : 6'b100_001;
      3'b011: g = fwd ? 6'b010_100 : 6'b100_010;
      3'b010: g = fwd ? 6'b010_001 : 6'b001_010;
      3'b110: g = fwd ? 6'b100_001 : 6'b001_100;
      3'b100: g = fwd ? 6'b100_010 : 6'b010_100;
      default: g = 6'h00;
    endcase
    return g;
  endfunction

  // =====================================================
  // register bus
  logic aw_got_ff, w_got_ff, bvalid_ff, awready_ff, wready_ff;
  logic arready_ff, rvalid_ff;
  logic [31:0] awaddr_ff, wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [1:0] ctrl_ff;
  logic [7:0] status_word;

  wire aw_hs = s_axi_awvalid & awready_ff;
  wire w_hs = s_axi_wvalid & wready_ff;
  wire have_aw = aw_got_ff | aw_hs;
  wire have_w = w_got_ff | w_hs;
  wire do_write = have_aw & have_w & ~bvalid_ff;
  wire nxt_aw_got = have_aw & ~do_write;
  wire nxt_w_got = have_w & ~do_write;
  wire nxt_bvalid = do_write | (bvalid_ff & ~s_axi_bready);
  wire [31:0] wr_addr = aw_got_ff ? awaddr_ff : s_axi_awaddr;
  wire [31:0] wr_data = w_got_ff ? wdata_ff : s_axi_wdata;
  wire [3:0] wr_strb = w_got_ff ? wstrb_ff : s_axi_wstrb;
  wire bpc_sel_t wr_sel = reg_sel(wr_addr);
  wire ar_hs = s_axi_arvalid & arready_ff;
  wire nxt_rvalid = ar_hs | (rvalid_ff & ~s_axi_rready);
  wire bpc_sel_t rd_sel = reg_sel(s_axi_araddr);
  wire [31:0] rd_word = (rd_sel == SEL_CTRL) ? {30'h0, ctrl_ff} :
                        (rd_sel == SEL_STATUS) ? {24'h0, status_word} : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      awaddr_ff <= 32'h0;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      ctrl_ff <= CTRL_RESET;
    end else begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      bvalid_ff <= nxt_bvalid;
      awready_ff <= ~nxt_aw_got & ~nxt_bvalid;
      wready_ff <= ~nxt_w_got & ~nxt_bvalid;
      if (aw_hs) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_write) begin
        bresp_ff <= (wr_sel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
        if (wr_sel == SEL_CTRL && wr_strb[0]) begin
          ctrl_ff <= wr_data[1:0];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= RESP_OKAY;
    end else begin
      rvalid_ff <= nxt_rvalid;
      arready_ff <= ~nxt_rvalid;
      if (ar_hs) begin
        rdata_ff <= rd_word;
        rresp_ff <= (rd_sel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
      end
    end
  end

  // =====================================================
  // input history
  logic [2:0] hall_prev_ff, hall_last_ff;
  logic dir_prev_ff, en_n_prev_ff, tri_prev_ff;
  wire [2:0] hall_now = {hall_sensor_c, hall_sensor_b, hall_sensor_a};
  wire hall_valid = (hall_now != 3'b000) && (hall_now != 3'b111);
  wire hall_edge = hall_now != hall_prev_ff;
  wire dir_edge = direction != dir_prev_ff;
  wire enable_on = en_n_prev_ff & ~drive_enable_n;
  wire tri_tick = lock_timer_capacitor & ~tri_prev_ff;
  wire braking = ~brake_request_n;
  wire sr_allowed = ctrl_ff[CTRL_SR_EN_BIT] & ~supply_overvoltage; // R15
  wire fault_hw = overtemp | pump_undervoltage | supply_undervoltage; // R13 R14 R16
  // a proper step moves to a new valid state that is not the one just left
  wire proper_step = hall_edge & hall_valid & (hall_now != hall_last_ff); // R19

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hall_prev_ff <= 3'h0;
      hall_last_ff <= 3'h0;
      dir_prev_ff <= 1'b0;
      en_n_prev_ff <= 1'b1;
      tri_prev_ff <= 1'b0;
    end else begin
      hall_prev_ff <= hall_now;
      dir_prev_ff <= direction;
      en_n_prev_ff <= drive_enable_n;
      tri_prev_ff <= lock_timer_capacitor;
      if (hall_edge && hall_valid) begin
        hall_last_ff <= hall_prev_ff;
      end
    end
  end

  // =====================================================
  // speed outputs
  logic fg_all_ff, fg_a_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fg_all_ff <= 1'b0;
      fg_a_ff <= 1'b0;
    end else begin
      fg_all_ff <= fg_all_ff ^ hall_edge; // R17
      fg_a_ff <= fg_a_ff ^ (hall_now[0] != hall_prev_ff[0]); // R18
    end
  end

  // =====================================================
  // fixed off-time and blanking
  bpc_chop_t chop_ff, nxt_chop;
  logic [8:0] chop_cnt_ff, nxt_chop_cnt;

  always_comb begin
    nxt_chop = chop_ff;
    nxt_chop_cnt = chop_cnt_ff + 9'h1;
    case (chop_ff)
      CH_DRIVE: begin
        nxt_chop_cnt = 9'h0;
        if (sense_trip) begin
          nxt_chop = CH_OFF; // R1
        end
      end
      CH_OFF: begin
        if (chop_cnt_ff == 9'(OFF_CYCLES - 1)) begin
          nxt_chop = CH_BLANK; // R2 R6
          nxt_chop_cnt = 9'h0;
        end
      end
      CH_BLANK: begin
        if (chop_cnt_ff == 9'(BLANK_CYCLES - 1)) begin
          nxt_chop = CH_DRIVE; // R6
          nxt_chop_cnt = 9'h0;
        end
      end
      default: begin
        nxt_chop = CH_BLANK;
        nxt_chop_cnt = 9'h0;
      end
    endcase
    if (dir_edge || enable_on) begin
      nxt_chop = CH_BLANK; // R7
      nxt_chop_cnt = 9'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chop_ff <= CH_BLANK;
      chop_cnt_ff <= 9'h0;
    end else begin
      chop_ff <= nxt_chop;
      chop_cnt_ff <= nxt_chop_cnt;
    end
  end

  // =====================================================
  // enable-high timer and standby
  logic [16:0] en_cnt_ff;
  logic standby_ff;
  wire en_expired = en_cnt_ff >= 17'(EN_HIGH_LIMIT); // R24
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_cnt_ff <= 17'h0;
      standby_ff <= 1'b0;
    end else begin
      if (!drive_enable_n) begin
        en_cnt_ff <= 17'h0;
      end else if (!en_expired) begin
        en_cnt_ff <= en_cnt_ff + 17'h1;
      end
      standby_ff <= en_expired & ~braking; // R11 R12
    end
  end

  // =====================================================
  // lock detect
  logic [6:0] lock_cnt_ff, half_cnt_ff;
  logic lock_ff;
  wire lock_run = ctrl_ff[CTRL_LOCK_EN_BIT] & ~braking & ~lock_ff; // R10
  wire lock_hit = lock_run & tri_tick & (lock_cnt_ff == 7'(LOCK_TRI_CYCLES - 1)); // R20
  wire half_hit = half_cnt_ff >= 7'(LOCK_HALF_CYCLES);
  wire lock_clear = dir_edge | supply_undervoltage | half_hit; // R22

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_cnt_ff <= 7'h0;
      half_cnt_ff <= 7'h0;
      lock_ff <= 1'b0;
    end else begin
      if (!drive_enable_n) begin
        half_cnt_ff <= 7'h0;
      end else if (tri_tick && !half_hit) begin
        half_cnt_ff <= half_cnt_ff + 7'h1;
      end
      if (proper_step || lock_clear || !lock_run) begin
        lock_cnt_ff <= 7'h0; // R19
      end else if (tri_tick) begin
        lock_cnt_ff <= lock_cnt_ff + 7'h1;
      end
      // a new timeout wins over a clear in the same cycle
      if (lock_hit) begin
        lock_ff <= 1'b1; // R21
      end else if (lock_clear) begin
        lock_ff <= 1'b0; // R22
      end
    end
  end

  // =====================================================
  // gate outputs
  wire [5:0] comm = commutate(hall_now, direction); // R23
  wire gates_off = fault_hw | lock_ff | en_expired; // R5 R13 R21
  wire decay = drive_enable_n | (chop_ff == CH_OFF); // R4
  logic [2:0] nxt_high, nxt_low;

  always_comb begin
    nxt_high = comm[5:3]; // R3
    nxt_low = comm[2:0];
    if (decay) begin
      nxt_high = 3'h0;
      if (sr_allowed) begin
        nxt_low = comm[2:0] | comm[5:3]; // R8
      end
    end
    if (braking) begin
      nxt_high = 3'h0; // R9 R10
      nxt_low = 3'h7;
    end
    if (fault_hw || (gates_off && !braking)) begin
      nxt_high = 3'h0;
      nxt_low = 3'h0;
    end
  end

  logic [2:0] gate_high_ff, gate_low_ff;
  logic hall_supply_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_high_ff <= 3'h0;
      gate_low_ff <= 3'h0;
      hall_supply_ff <= 1'b0;
    end else begin
      gate_high_ff <= nxt_high;
      gate_low_ff <= nxt_low;
      hall_supply_ff <= ~standby_ff; // R11
    end
  end

  assign status_word = {standby_ff, lock_ff, supply_overvoltage, supply_undervoltage,
                        pump_undervoltage, overtemp, braking, decay};
  assign gate_high = gate_high_ff;
  assign gate_low = gate_low_ff;
  assign hall_supply_output = hall_supply_ff;
  assign speed_pulse_all_sensors = fg_all_ff;
  assign speed_pulse_phase_a = fg_a_ff;
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // =====================================================
  // checks
  chk_trip_starts_off: assert property (@(posedge aclk) disable iff (!aresetn) // R1
    (chop_ff == CH_DRIVE && sense_trip && !dir_edge && !enable_on) |=> chop_ff == CH_OFF)
    else $error("trip did not start off-time");
  chk_off_time_len: assert property (@(posedge aclk) disable iff (!aresetn) // R2
    (chop_ff == CH_OFF && chop_cnt_ff == 9'h0 && !drive_enable_n)
      ##1 (!dir_edge && !enable_on) [*8] |-> chop_ff == CH_OFF)
    else $error("off-time ended too early");
  chk_blank_ignores_trip: assert property (@(posedge aclk) disable iff (!aresetn) // R6
    (chop_ff == CH_BLANK && sense_trip) |=> chop_ff != CH_OFF)
    else $error("trip taken during blanking");
  chk_dir_restart_blank: assert property (@(posedge aclk) disable iff (!aresetn) // R7
    dir_edge |=> chop_ff == CH_BLANK && chop_cnt_ff == 9'h0)
    else $error("blanking not restarted");
  chk_brake_sinks_on: assert property (@(posedge aclk) disable iff (!aresetn) // R9
    (braking && !fault_hw) |=> gate_low == 3'h7 && gate_high == 3'h0)
    else $error("brake did not turn on sinks");
  chk_fault_gates_off: assert property (@(posedge aclk) disable iff (!aresetn) // R13
    fault_hw |=> gate_low == 3'h0 && gate_high == 3'h0)
    else $error("fault left gates on");
  chk_ov_no_rectify: assert property (@(posedge aclk) disable iff (!aresetn) // R15
    (supply_overvoltage && drive_enable_n && !braking) |=> gate_low == $past(comm[2:0]) || gate_low == 3'h0)
    else $error("rectification during overvoltage");
  chk_fg_all_toggle: assert property (@(posedge aclk) disable iff (!aresetn) // R17
    hall_edge |=> speed_pulse_all_sensors != $past(speed_pulse_all_sensors))
    else $error("speed output missed hall edge");
  chk_lock_gates_off: assert property (@(posedge aclk) disable iff (!aresetn) // R21
    (lock_hit && !braking) |=> lock_ff ##1 (gate_high == 3'h0 || lock_clear))
    else $error("lock did not disable outputs");
  chk_standby_supply: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    standby_ff |=> !hall_supply_output)
    else $error("hall supply left on in standby");

endmodule
`default_nettype wire

// ### verification/bpc_mcu_model.sv
// Purpose: controller model that drives enable, direction and brake
// Assumes: bench commands {enable_n, direction, brake_n}, applied on aclk
// Notes: slow adds one register stage so the far side answers late
`timescale 1ns/1ps
`default_nettype none
module bpc_mcu_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  input wire logic [2:0] cmd,
  output logic drive_enable_n,
  output logic direction,
  output logic brake_request_n
);
  logic [2:0] stage_ff;
  logic [2:0] nxt_out;
  // ==========================================
  // command pipeline
  assign nxt_out = slow ? stage_ff : cmd;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage_ff <= 3'h7;
      {drive_enable_n, direction, brake_request_n} <= 3'h7;
    end else begin
      stage_ff <= cmd;
      // brake follows the command; the model does not force brake high when standby is asked for
      {drive_enable_n, direction, brake_request_n} <= nxt_out;
    end
  end
endmodule
`default_nettype wire

// ### verification/test_bpc_top.sv
// Purpose: self-checking bench for the pre-driver control block
// Assumes: enable limit shortened to 200 cycles
// Notes: cmd packs {enable_n, direction, brake_n}
`timescale 1ns/1ps
`default_nettype none
module test_bpc_top;
  import bpc_pkg::*;
  localparam int LIMIT = 200;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rd, r;
  logic [3:0] wstrb = 4'hf;
  logic [2:0] hall = 3'h0, cmd = 3'h7, gh, gl;
  logic trip = 1'b0, ot = 1'b0, puv = 1'b0, suv = 1'b0, sov = 1'b0, cap = 1'b0, slow = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, en_n, dir, brk_n, hsup, fg1, fg2;
  logic [1:0] bresp, rresp, resp;
  logic fg1_exp = 1'b0, fg2_exp = 1'b0;
  logic [31:0] seed = 32'h0001_2b01;
  int num_errors = 0, num_checks = 0;

  always #25 aclk = ~aclk;

  bpc_top #(.EN_HIGH_LIMIT(LIMIT)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .drive_enable_n(en_n), .direction(dir), .brake_request_n(brk_n), .hall_sensor_a(hall[0]),
    .hall_sensor_b(hall[1]), .hall_sensor_c(hall[2]), .sense_trip(trip), .overtemp(ot),
    .pump_undervoltage(puv), .supply_undervoltage(suv), .supply_overvoltage(sov),
    .lock_timer_capacitor(cap), .gate_high(gh), .gate_low(gl), .hall_supply_output(hsup),
    .speed_pulse_all_sensors(fg1), .speed_pulse_phase_a(fg2));

  bpc_mcu_model mcu (.aclk(aclk), .aresetn(aresetn), .slow(slow), .cmd(cmd), .drive_enable_n(en_n),
    .direction(dir), .brake_request_n(brk_n));

  // ==========================================
  // expectations
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // {high, low} per hall word {c,b,a}; reverse swaps the two sides
  function automatic logic [5:0] comm(input logic [2:0] h, input logic d);
    logic [5:0] f;
    case (h)
      3'h5: f = 6'h0a;
      3'h1: f = 6'h0c;
      3'h3: f = 6'h14;
      3'h2: f = 6'h11;
      3'h6: f = 6'h21;
      3'h4: f = 6'h22;
      default: f = 6'h00;
    endcase
    return d ? f : {f[2:0], f[5:3]};
  endfunction
  function automatic logic [5:0] chop(input logic [2:0] h, input logic d, input logic sr);
    logic [5:0] f;
    f = comm(h, d);
    return {3'h0, f[2:0] | (sr ? f[5:3] : 3'h0)};
  endfunction

  // ==========================================
  // helpers
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic gates(input logic [5:0] e);
    check("gates", {26'h0, e}, {26'h0, gh, gl});
  endtask
  task automatic done(input string t);
    $display("test %s done, errors %0d", t, num_errors);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] rs);
    bit aw_ok = 1'b0;
    bit w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    rs = 2'h2;
    for (int n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (bvalid) begin
        rs = (aw_ok && w_ok) ? bresp : 2'h2;
        break;
      end
      if (awready) aw_ok = 1'b1;
      if (awready) awvalid <= 1'b0;
      if (wready) w_ok = 1'b1;
      if (wready) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    tick(1);
  endtask
  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] rs);
    bit a_ok = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rs = 2'h2;
    d = 32'h0;
    for (int n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (a_ok && rvalid) begin
        d = rdata;
        rs = rresp;
        break;
      end
      if (arready) a_ok = 1'b1;
      if (arready) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    tick(1);
  endtask
  task automatic drv(input logic [2:0] c);
    cmd <= c;
    tick(6);
  endtask
  task automatic set_hall(input logic [2:0] h);
    fg1_exp ^= (h != hall);
    fg2_exp ^= (h[0] != hall[0]);
    hall <= h;
    tick(3);
  endtask
  task automatic tri_cycles(input int n);
    repeat (n) begin
      cap <= 1'b1;
      tick(2);
      cap <= 1'b0;
      tick(2);
    end
  endtask

  // ==========================================
  // watchdog: the tests take about 4200 cycles
  initial begin
    tick(30000);
    num_errors++;
    results();
  end

  // ==========================================
  // tests
  initial begin
    tick(4);
    gates(6'h00);
    aresetn <= 1'b1;
    tick(3);
    check("hall supply", 32'h1, {31'h0, hsup});
    axi_rd(CTRL_ADDR, rd, resp);
    check("ctrl", {30'h0, CTRL_RESET}, rd);
    check("ctrl resp", {30'h0, RESP_OKAY}, {30'h0, resp});
    axi_rd(32'h0000_0008, rd, resp);
    check("unmapped rd", {30'h0, RESP_DECERR}, {30'h0, resp});
    axi_wr(32'h0000_0040, 32'h0, resp);
    check("unmapped wr", {30'h0, RESP_DECERR}, {30'h0, resp});
    axi_wr(STATUS_ADDR, 32'hffff_ffff, resp);
    check("status wr", {30'h0, RESP_OKAY}, {30'h0, resp});
    done("registers");
    for (int d = 1; d >= 0; d--) begin
      drv({2'(d), 1'b1});
      for (int h = 0; h < 8; h++) begin
        set_hall(3'(h));
        gates(comm(3'(h), d[0]));
      end
    end
    done("commutation");
    set_hall(3'h5);
    drv(3'h7);
    gates(chop(3'h5, 1'b1, 1'b1));
    sov <= 1'b1;
    tick(3);
    gates(chop(3'h5, 1'b1, 1'b0));
    sov <= 1'b0;
    axi_wr(CTRL_ADDR, 32'h2, resp);
    gates(chop(3'h5, 1'b1, 1'b0));
    axi_wr(CTRL_ADDR, 32'h3, resp);
    drv(3'h3);
    tick(40);
    trip <= 1'b1;
    tick(1);
    trip <= 1'b0;
    tick(3);
    gates(chop(3'h5, 1'b1, 1'b1));
    tick(476);
    gates(chop(3'h5, 1'b1, 1'b1));
    tick(40);
    gates(comm(3'h5, 1'b1));
    cmd <= 3'h1;
    tick(2);
    trip <= 1'b1;
    tick(10);
    gates(comm(3'h5, 1'b0));
    tick(40);
    gates(chop(3'h5, 1'b0, 1'b1));
    trip <= 1'b0;
    tick(540);
    done("chopping");
    slow <= 1'b1;
    drv(3'h4);
    gates(6'h07);
    tick(250);
    gates(6'h07);
    check("hall supply", 32'h1, {31'h0, hsup});
    axi_rd(STATUS_ADDR, rd, resp);
    check("braking", 32'h2, rd & 32'h2);
    drv(3'h5);
    tick(250);
    gates(6'h00);
    check("hall supply", 32'h0, {31'h0, hsup});
    slow <= 1'b0;
    drv(3'h1);
    tick(40);
    gates(comm(3'h5, 1'b0));
    check("hall supply", 32'h1, {31'h0, hsup});
    done("brake standby");
    for (int i = 0; i < 3; i++) begin
      {ot, puv, suv} <= 3'h1 << i;
      tick(3);
      gates(6'h00);
      {ot, puv, suv} <= 3'h0;
      tick(40);
      gates(comm(3'h5, 1'b0));
    end
    done("faults");
    repeat (60) begin
      r = xs();
      set_hall(r[2:0]);
      check("fg1", {31'h0, fg1_exp}, {31'h0, fg1});
      check("fg2", {31'h0, fg2_exp}, {31'h0, fg2});
      gates(comm(r[2:0], 1'b0));
    end
    done("speed");
    set_hall(3'h5);
    tri_cycles(120);
    gates(comm(3'h5, 1'b0));
    tri_cycles(15);
    gates(6'h00);
    axi_rd(STATUS_ADDR, rd, resp);
    check("lock", 32'h40, rd & 32'h40);
    drv(3'h3);
    tick(40);
    gates(comm(3'h5, 1'b1));
    drv(3'h2);
    tri_cycles(135);
    gates(6'h07);
    drv(3'h3);
    tick(40);
    gates(comm(3'h5, 1'b1));
    tri_cycles(135);
    gates(6'h00);
    cmd <= 3'h7;
    tri_cycles(70);
    drv(3'h3);
    tick(40);
    gates(comm(3'h5, 1'b1));
    done("lock");
    results();
  end
endmodule
`default_nettype wire
